// ==== src/cpuex_pkg.sv ====
// Constants, types and state layout of the exception sequencer
package cpuex_pkg;
   localparam logic [4:0]  MODE_USR = 5'h10;
   localparam logic [4:0]  MODE_FIQ = 5'h11;
   localparam logic [4:0]  MODE_IRQ = 5'h12;
   localparam logic [4:0]  MODE_SVC = 5'h13;
   localparam logic [4:0]  MODE_ABT = 5'h17;
   localparam logic [4:0]  MODE_UND = 5'h1b;
   localparam logic [31:0] VEC_RESET = 32'h00;
   localparam logic [31:0] VEC_UNDEF = 32'h04;
   localparam logic [31:0] VEC_SWI   = 32'h08;
   localparam logic [31:0] VEC_PABT  = 32'h0c;
   localparam logic [31:0] VEC_DABT  = 32'h10;
   localparam logic [31:0] VEC_IRQ   = 32'h18;
   localparam logic [31:0] VEC_FIQ   = 32'h1c;
   localparam logic [31:0] OFS_WORD  = 32'h4;
   localparam logic [31:0] OFS_DWORD = 32'h8;
   localparam logic [31:0] OFS_HALF  = 32'h2;
   localparam int          BANKS     = 5;
   localparam logic [2:0]  BK_SVC = 3'h0;
   localparam logic [2:0]  BK_ABT = 3'h1;
   localparam logic [2:0]  BK_UND = 3'h2;
   localparam logic [2:0]  BK_IRQ = 3'h3;
   localparam logic [2:0]  BK_FIQ = 3'h4;
   localparam logic [2:0]  BK_NONE = 3'h7;
   localparam int          BIT_I = 7;
   localparam int          BIT_F = 6;
   localparam logic [7:0]  ADDR_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_SAVED  = 8'h04;
   localparam logic [7:0]  ADDR_LINK   = 8'h08;
   localparam logic [7:0]  ADDR_TARGET = 8'h0c;
   localparam logic [7:0]  ADDR_EVENT  = 8'h10;
   localparam logic [1:0]  CLS_SINGLE = 2'h0;
   localparam logic [1:0]  CLS_SWAP   = 2'h1;
   localparam logic [1:0]  CLS_BLOCK  = 2'h2;

   typedef enum logic [6:0] {
      EXC_NONE  = 7'h00,
      EXC_DABT  = 7'h01,
      EXC_FIQ   = 7'h02,
      EXC_IRQ   = 7'h04,
      EXC_PABT  = 7'h08,
      EXC_UNDEF = 7'h10,
      EXC_SWI   = 7'h20,
      EXC_RESET = 7'h40
   } cpuex_kind_e;

   typedef struct packed {
      logic       i;
      logic       f;
      logic       t;
      logic [4:0] mode;
   } cpuex_status_s;

   typedef struct packed {
      logic                       inReset;
      logic [31:0]                pcValue;
      logic                       pcLoad;
      cpuex_status_s              status;
      logic [BANKS-1:0][31:0]     link;
      cpuex_status_s [BANKS-1:0]  saved;
      logic                       pendFetch;
      logic                       pendData;
      logic                       regInhibit;
      logic                       baseWb;
      logic                       swapCancel;
      logic                       fastSync_n;
      cpuex_kind_e                lastKind;
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
   } cpuex_state_s;

   function automatic logic [2:0] cpuex_bank(input logic [4:0] mode);
      logic [2:0] b;
      b = BK_NONE;
      if (mode == MODE_SVC) b = BK_SVC;
      else if (mode == MODE_ABT) b = BK_ABT;
      else if (mode == MODE_UND) b = BK_UND;
      else if (mode == MODE_IRQ) b = BK_IRQ;
      else if (mode == MODE_FIQ) b = BK_FIQ;
      return b;
   endfunction
endpackage

// ==== src/cpuex_sequencer.sv ====
// Exception entry, exit and reset sequencing with an APB status port
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module cpuex_sequencer
   import cpuex_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        abortIn,
   input  wire logic        fetchCycle,
   input  wire logic        flushPipe,
   input  wire logic        dataCycle,
   input  wire logic [1:0]  dataClass,
   input  wire logic        blockWbSet,
   input  wire logic        stepValid,
   input  wire logic [31:0] stepPc,
   input  wire logic [31:0] nextPc,
   input  wire logic        stepUndef,
   input  wire logic        stepSwTrap,
   input  wire logic        irqReq,
   input  wire logic [2:0]  fastSrc,
   input  wire logic        retReq,
   input  wire logic [3:0]  retSub,
   output logic [31:0]      pcValue,
   output logic             pcLoad,
   output logic [7:0]       curStatus,
   output logic             baseWb,
   output logic             swapCancel,
   output logic             regInhibit,
   output logic [6:0]       lastKind
);
   cpuex_state_s s_r;
   cpuex_state_s s_nxt;
   cpuex_kind_e  takeKind;
   logic [31:0]  takeVec;
   logic [31:0]  takeLink;
   logic [4:0]   takeMode;
   logic [2:0]   takeBank;
   logic [2:0]   curBank;
   logic         apbAccess;

   ////////////////////////////////////////////////////////////////////////////
   // Exception selection at the end of an instruction
   always_comb begin
      takeKind = EXC_NONE;
      takeVec  = VEC_RESET;
      takeLink = stepPc + OFS_WORD;
      takeMode = s_r.status.mode;
      takeBank = BK_NONE;
      curBank  = cpuex_bank(s_r.status.mode);
      if (stepValid && !s_r.inReset) begin
         // Fixed order; reset is handled before this point
         if (s_r.pendData) begin
            takeKind = EXC_DABT;
            takeVec  = VEC_DABT;
            takeLink = stepPc + OFS_DWORD;
            takeMode = MODE_ABT;
            takeBank = BK_ABT;
         end else if (!s_r.status.f && !s_r.fastSync_n) begin
            takeKind = EXC_FIQ;
            takeVec  = VEC_FIQ;
            takeLink = nextPc + OFS_WORD;
            takeMode = MODE_FIQ;
            takeBank = BK_FIQ;
         end else if (!s_r.status.i && irqReq) begin
            takeKind = EXC_IRQ;
            takeVec  = VEC_IRQ;
            takeLink = nextPc + OFS_WORD;
            takeMode = MODE_IRQ;
            takeBank = BK_IRQ;
         end else if (s_r.pendFetch) begin
            takeKind = EXC_PABT;
            takeVec  = VEC_PABT;
            takeLink = stepPc + OFS_WORD;
            takeMode = MODE_ABT;
            takeBank = BK_ABT;
         end else if (stepUndef || stepSwTrap) begin
            // Compact state uses a half-word step so one return fits both
            takeKind = stepUndef ? EXC_UNDEF : EXC_SWI;
            takeVec  = stepUndef ? VEC_UNDEF : VEC_SWI;
            takeLink = stepPc + (s_r.status.t ? OFS_HALF : OFS_WORD);
            takeMode = stepUndef ? MODE_UND : MODE_SVC;
            takeBank = stepUndef ? BK_UND : BK_SVC;
         end
      end
   end

   assign apbAccess = psel && penable && s_r.pready;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_nxt            = s_r;
      s_nxt.pcLoad     = 1'b0;
      s_nxt.baseWb     = 1'b0;
      s_nxt.swapCancel = 1'b0;
      s_nxt.pready     = 1'b0;
      s_nxt.pslverr    = 1'b0;
      // Only the timer and watchdog lines feed the fast request
      s_nxt.fastSync_n = ~|fastSrc;
      if (!rst_n) begin
         // Keep stepping the fetch address by one word
         s_nxt.inReset    = 1'b1;
         // An unknown flag at power-up must fall to the restart branch
         if (s_r.inReset) begin
            s_nxt.pcValue = s_r.pcValue + OFS_WORD;
         end else begin
            s_nxt.pcValue = VEC_RESET;
            // Known status on entry keeps the saved copy free of unknowns
            s_nxt.status.i    = 1'b1;
            s_nxt.status.f    = 1'b1;
            s_nxt.status.t    = 1'b0;
            s_nxt.status.mode = MODE_SVC;
         end
         s_nxt.pendFetch  = 1'b0;
         s_nxt.pendData   = 1'b0;
         s_nxt.regInhibit = 1'b0;
         s_nxt.fastSync_n = 1'b1;
         s_nxt.lastKind   = EXC_RESET;
         s_nxt.prdata     = 32'h0;
      end else if (s_r.inReset) begin
         // Saved values carry whatever was there; software must not trust them
         s_nxt.link[BK_SVC]  = s_r.pcValue;
         s_nxt.saved[BK_SVC] = s_r.status;
         s_nxt.status.mode   = MODE_SVC;
         s_nxt.status.i      = 1'b1;
         s_nxt.status.f      = 1'b1;
         s_nxt.status.t      = 1'b0;
         s_nxt.pcValue       = VEC_RESET;
         s_nxt.pcLoad        = 1'b1;
         s_nxt.inReset       = 1'b0;
      end else begin
         // Abort sampled only in memory cycles
         if (flushPipe) begin
            s_nxt.pendFetch = 1'b0;
         end else if (fetchCycle) begin
            s_nxt.pendFetch = abortIn;
         end else if (stepValid) begin
            s_nxt.pendFetch = 1'b0;
         end
         // Register port: no wait state, mask bits writable when privileged
         if (psel && !penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0;
            if (paddr == ADDR_STATUS) begin
               s_nxt.prdata = {24'h0, s_r.status};
            end else if (paddr == ADDR_SAVED) begin
               s_nxt.prdata = (curBank == BK_NONE) ? 32'h0 : {24'h0, s_r.saved[curBank]};
            end else if (paddr == ADDR_LINK) begin
               s_nxt.prdata = (curBank == BK_NONE) ? 32'h0 : s_r.link[curBank];
            end else if (paddr == ADDR_TARGET) begin
               s_nxt.prdata = s_r.pcValue;
            end else if (paddr == ADDR_EVENT) begin
               s_nxt.prdata = {23'h0, s_r.regInhibit, s_r.pendData, s_r.lastKind};
            end else begin
               s_nxt.pslverr = 1'b1;
            end
         end
         if (apbAccess && pwrite && paddr == ADDR_STATUS && s_r.status.mode != MODE_USR) begin
            s_nxt.status.i = pwdata[BIT_I];
            s_nxt.status.f = pwdata[BIT_F];
         end
         if (takeKind != EXC_NONE) begin
            s_nxt.link[takeBank]  = takeLink;
            s_nxt.saved[takeBank] = s_r.status;
            s_nxt.status.mode     = takeMode;
            s_nxt.status.t        = 1'b0;
            s_nxt.pcValue         = takeVec;
            s_nxt.pcLoad          = 1'b1;
            s_nxt.lastKind        = takeKind;
            s_nxt.pendFetch       = 1'b0;
            s_nxt.pendData        = 1'b0;
            s_nxt.regInhibit      = 1'b0;
            if (takeKind == EXC_IRQ || takeKind == EXC_FIQ) begin
               s_nxt.status.i = 1'b1;
            end
            if (takeKind == EXC_FIQ) begin
               s_nxt.status.f = 1'b1;
            end
         end else if (retReq && curBank != BK_NONE) begin
            // Saved copy brings back masks and compact bit
            s_nxt.pcValue = s_r.link[curBank] - {28'h0, retSub};
            s_nxt.status  = s_r.saved[curBank];
            s_nxt.pcLoad  = 1'b1;
         end else if (stepValid) begin
            s_nxt.regInhibit = 1'b0;
         end
         // Captured last so a fresh abort beats a same-cycle clear
         if (dataCycle && abortIn) begin
            s_nxt.pendData = 1'b1;
            if (dataClass == CLS_SINGLE) begin
               s_nxt.baseWb = 1'b1;
            end else if (dataClass == CLS_SWAP) begin
               s_nxt.swapCancel = 1'b1;
            end else if (dataClass == CLS_BLOCK) begin
               s_nxt.regInhibit = 1'b1;
               s_nxt.baseWb     = blockWbSet;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end

   assign prdata     = s_r.prdata;
   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
   assign pcValue    = s_r.pcValue;
   assign pcLoad     = s_r.pcLoad;
   assign curStatus  = s_r.status;
   assign baseWb     = s_r.baseWb;
   assign swapCancel = s_r.swapCancel;
   assign regInhibit = s_r.regInhibit;
   assign lastKind   = s_r.lastKind;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_release;
      s_r.inReset && rst_n;
   endsequence

   sequence s_supervisorWide;
      s_r.status.mode == MODE_SVC && s_r.status.i && s_r.status.f && !s_r.status.t;
   endsequence

   property p_rstFetch;
      @(posedge sys_clk) disable iff (1'b0)
      (!rst_n && s_r.inReset) |=> (s_r.pcValue == $past(s_r.pcValue) + OFS_WORD);
   endproperty
   a_rstFetch: assert property (p_rstFetch) else $error("reset fetch not stepping");

   property p_rstSave;
      @(posedge sys_clk) disable iff (!rst_n)
      s_release |=> (s_r.link[BK_SVC] == $past(s_r.pcValue))
                    && (s_r.saved[BK_SVC] == $past(s_r.status));
   endproperty
   a_rstSave: assert property (p_rstSave) else $error("reset save wrong");

   property p_rstMode;
      @(posedge sys_clk) disable iff (!rst_n)
      s_release |=> s_supervisorWide ##0 (s_r.pcLoad && s_r.pcValue == VEC_RESET);
   endproperty
   a_rstMode: assert property (p_rstMode) else $error("reset exit state wrong");

   property p_dabtFirst;
      @(posedge sys_clk) disable iff (!rst_n)
      (stepValid && s_r.pendData && !s_r.inReset)
         |=> (s_r.status.mode == MODE_ABT && s_r.pcValue == VEC_DABT
              && s_r.link[BK_ABT] == $past(stepPc) + OFS_DWORD);
   endproperty
   a_dabtFirst: assert property (p_dabtFirst) else $error("data abort not served first");

   property p_fiqMasked;
      @(posedge sys_clk) disable iff (!rst_n)
      (stepValid && s_r.status.f && !s_r.pendData)
         |=> !(s_r.pcLoad && s_r.pcValue == VEC_FIQ);
   endproperty
   a_fiqMasked: assert property (p_fiqMasked) else $error("masked fast interrupt taken");

   property p_irqEntry;
      @(posedge sys_clk) disable iff (!rst_n)
      (takeKind == EXC_IRQ)
         |=> (s_r.status.i && s_r.status.mode == MODE_IRQ && !s_r.status.t
              && s_r.link[BK_IRQ] == $past(nextPc) + OFS_WORD);
   endproperty
   a_irqEntry: assert property (p_irqEntry) else $error("normal interrupt entry wrong");

   property p_swapCancel;
      @(posedge sys_clk) disable iff (!rst_n)
      (dataCycle && abortIn && dataClass == CLS_SWAP && !s_r.inReset)
         |=> (swapCancel && !baseWb) ##1 !swapCancel;
   endproperty
   a_swapCancel: assert property (p_swapCancel) else $error("swap abort not cancelled");

   property p_blockHold;
      @(posedge sys_clk) disable iff (!rst_n)
      (regInhibit && !stepValid && !retReq) |=> regInhibit;
   endproperty
   a_blockHold: assert property (p_blockHold) else $error("overwrite block dropped early");

   property p_exit;
      @(posedge sys_clk) disable iff (!rst_n)
      (retReq && takeKind == EXC_NONE && curBank != BK_NONE && !s_r.inReset)
         |=> (s_r.status == $past(s_r.saved[curBank])
              && s_r.pcValue == $past(s_r.link[curBank]) - {28'h0, $past(retSub)});
   endproperty
   a_exit: assert property (p_exit) else $error("exception exit wrong");

   property p_flush;
      @(posedge sys_clk) disable iff (!rst_n)
      (flushPipe && !s_r.inReset) |=> !s_r.pendFetch;
   endproperty
   a_flush: assert property (p_flush) else $error("flushed prefetch abort kept");

   sequence s_entry;
      stepValid && takeKind != EXC_NONE && !s_r.inReset;
   endsequence

   property p_fiqEntry;
      @(posedge sys_clk) disable iff (!rst_n)
      (takeKind == EXC_FIQ)
         |=> (s_r.status.i && s_r.status.f && s_r.status.mode == MODE_FIQ
              && s_r.link[BK_FIQ] == $past(nextPc) + OFS_WORD);
   endproperty
   a_fiqEntry: assert property (p_fiqEntry) else $error("fast entry wrong");

   property p_wideEntry;
      @(posedge sys_clk) disable iff (!rst_n)
      s_entry |=> (!s_r.status.t && s_r.pcLoad);
   endproperty
   a_wideEntry: assert property (p_wideEntry) else $error("entry left compact");

   property p_undefSave;
      @(posedge sys_clk) disable iff (!rst_n)
      (takeKind == EXC_UNDEF)
         |=> (s_r.saved[BK_UND] == $past(s_r.status) && s_r.status.mode == MODE_UND
              && s_r.pcValue == VEC_UNDEF);
   endproperty
   a_undefSave: assert property (p_undefSave) else $error("undefined entry wrong");

   property p_trapLink;
      @(posedge sys_clk) disable iff (!rst_n)
      (takeKind == EXC_SWI)
         |=> (s_r.link[BK_SVC] == $past(stepPc) + ($past(s_r.status.t) ? OFS_HALF : OFS_WORD));
   endproperty
   a_trapLink: assert property (p_trapLink) else $error("trap link wrong");

   property p_singleWb;
      @(posedge sys_clk) disable iff (!rst_n)
      (dataCycle && abortIn && dataClass == CLS_SINGLE && !s_r.inReset)
         |=> (baseWb && !swapCancel && s_r.pendData);
   endproperty
   a_singleWb: assert property (p_singleWb) else $error("single abort lost base");

   property p_blockSet;
      @(posedge sys_clk) disable iff (!rst_n)
      (dataCycle && abortIn && dataClass == CLS_BLOCK && !s_r.inReset)
         |=> (regInhibit && baseWb == $past(blockWbSet));
   endproperty
   a_blockSet: assert property (p_blockSet) else $error("block abort not held");

   property p_loadCause;
      @(posedge sys_clk) disable iff (!rst_n)
      (!stepValid && !retReq && !s_r.inReset) |=> !s_r.pcLoad;
   endproperty
   a_loadCause: assert property (p_loadCause) else $error("load without head step");

   property p_fastSync;
      @(posedge sys_clk) disable iff (!rst_n)
      (fastSrc != 3'h0) |=> !s_r.fastSync_n;
   endproperty
   a_fastSync: assert property (p_fastSync) else $error("fast request not seen");

   property p_irqBelow;
      @(posedge sys_clk) disable iff (!rst_n)
      (stepValid && irqReq && !s_r.status.i && !s_r.status.f && !s_r.fastSync_n
       && !s_r.pendData && !s_r.inReset)
         |=> (s_r.status.mode == MODE_FIQ);
   endproperty
   a_irqBelow: assert property (p_irqBelow) else $error("fast lost to normal");
endmodule

// ==== testbench/cpuex_far_model.sv ====
// Far-side model: memory abort flag and interrupt sources
`timescale 1ns/100ps
module cpuex_far_model (
   input  wire logic       sys_clk,
   input  wire logic       fetchCycle,
   input  wire logic       dataCycle,
   input  wire logic       faultOn,
   input  wire logic       irqOn,
   input  wire logic [2:0] timerOn,
   output logic            abortIn,
   output logic            irqReq,
   output logic [2:0]      fastSrc
);
   logic noise_r = 1'h0;
   ////////////////////////////////////////////////////////////////////////////
   // Off access cycles the flag carries garbage, so a sloppy sampler shows up
   always_ff @(posedge sys_clk) begin
      noise_r <= ~noise_r;
   end
   assign abortIn = (fetchCycle | dataCycle) ? faultOn : noise_r;
   // Fast bits: timer 1, timer 2, watchdog; nothing else may reach them
   assign fastSrc = timerOn;
   assign irqReq  = irqOn;
endmodule

// ==== testbench/tb_cpu_exception_sequencer.sv ====
// Self-checking bench for the exception sequencer
`timescale 1ns/100ps
module tb_cpu_exception_sequencer
   import cpuex_pkg::*;
();
   typedef struct packed {
      logic        und, swt, irq;
      logic [2:0]  fast;
      logic [31:0] pc, vec;
      logic [7:0]  st;
      logic [6:0]  kd;
      logic [31:0] lk;
      logic [3:0]  sub;
   } cpuex_row_s;
   logic        sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        fetchCycle = 1'h0, flushPipe = 1'h0, dataCycle = 1'h0, blockWbSet = 1'h0;
   logic        stepValid = 1'h0, stepUndef = 1'h0, stepSwTrap = 1'h0, retReq = 1'h0;
   logic        faultOn = 1'h0, irqOn = 1'h0;
   logic        pready, pslverr, abortIn, irqReq, pcLoad, baseWb, swapCancel, regInhibit;
   logic [1:0]  dataClass = 2'h0;
   logic [2:0]  timerOn = 3'h0, fastSrc;
   logic [3:0]  retSub = 4'h0;
   logic [6:0]  lastKind;
   logic [7:0]  paddr = 8'h0, curStatus;
   logic [31:0] pwdata = 32'h0, stepPc = 32'h0, nextPc = 32'h0, prdata, pcValue;
   int          bad_count = 0, checked = 0;
   // Entries start from supervisor mode with both masks clear
   cpuex_row_s  rows [7] = '{
      '{1'h1, 1'h0, 1'h0, 3'h0, 32'h100, VEC_UNDEF, 8'h1b, 7'h10, 32'h104, 4'h0},
      '{1'h0, 1'h1, 1'h0, 3'h0, 32'h200, VEC_SWI, 8'h13, 7'h20, 32'h204, 4'h0},
      '{1'h0, 1'h0, 1'h1, 3'h0, 32'h300, VEC_IRQ, 8'h92, 7'h04, 32'h308, 4'h4},
      '{1'h0, 1'h0, 1'h0, 3'h1, 32'h400, VEC_FIQ, 8'hd1, 7'h02, 32'h408, 4'h4},
      '{1'h1, 1'h0, 1'h1, 3'h4, 32'h500, VEC_FIQ, 8'hd1, 7'h02, 32'h508, 4'h4},
      '{1'h0, 1'h1, 1'h1, 3'h0, 32'h600, VEC_IRQ, 8'h92, 7'h04, 32'h608, 4'h4},
      '{1'h0, 1'h0, 1'h0, 3'h2, 32'h700, VEC_FIQ, 8'hd1, 7'h02, 32'h708, 4'h4}};

   always #12.5 sys_clk = ~sys_clk;

   cpuex_sequencer i_dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .abortIn, .fetchCycle, .flushPipe, .dataCycle, .dataClass,
      .blockWbSet, .stepValid, .stepPc, .nextPc, .stepUndef, .stepSwTrap, .irqReq, .fastSrc,
      .retReq, .retSub, .pcValue, .pcLoad, .curStatus, .baseWb, .swapCancel, .regInhibit,
      .lastKind);
   cpuex_far_model i_far (.sys_clk, .fetchCycle, .dataCycle, .faultOn, .irqOn, .timerOn,
      .abortIn, .irqReq, .fastSrc);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Ends one edge after release so a following setup never collides
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      // Ready, data and error are read at the edge they are sampled on
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (n >= 16) begin
         bad_count++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      logic        e;
      apb(1'h0, a, 32'h0, d, e);
      chk(nm, d, exp);
   endtask

   task automatic step(input logic [31:0] pc, input logic und, input logic swt);
      stepValid  <= 1'h1;
      stepPc     <= pc;
      nextPc     <= pc + 32'h4;
      stepUndef  <= und;
      stepSwTrap <= swt;
      @(posedge sys_clk);
      stepValid  <= 1'h0;
      stepUndef  <= 1'h0;
      stepSwTrap <= 1'h0;
      irqOn      <= 1'h0;
      timerOn    <= 3'h0;
      @(negedge sys_clk);
   endtask

   task automatic access(input logic isData, input logic [1:0] cls);
      faultOn    <= 1'h1;
      fetchCycle <= ~isData;
      dataCycle  <= isData;
      dataClass  <= cls;
      blockWbSet <= 1'h1;
      @(posedge sys_clk);
      faultOn    <= 1'h0;
      fetchCycle <= 1'h0;
      dataCycle  <= 1'h0;
      blockWbSet <= 1'h0;
      @(negedge sys_clk);
   endtask

   // Entry seen at the negedge after the step, then handler return
   task automatic exc(input logic [31:0] vec, input logic [7:0] st, input logic [6:0] kd,
                      input logic [31:0] lk, input logic [3:0] sub);
      chk("pcLoad", 32'(pcLoad), 32'h1);
      chk("vector", pcValue, vec);
      chk("status", 32'(curStatus), 32'(st));
      chk("kind", 32'(lastKind), 32'(kd));
      @(posedge sys_clk);
      rdchk(ADDR_LINK, lk, "link");
      rdchk(ADDR_SAVED, 32'h13, "saved");
      retReq <= 1'h1;
      retSub <= sub;
      @(posedge sys_clk);
      retReq <= 1'h0;
      @(negedge sys_clk);
      chk("retPc", pcValue, lk - 32'(sub));
      chk("retStatus", 32'(curStatus), 32'h13);
      @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic        e;
      for (int k = 0; k < 5; k++) begin
         @(negedge sys_clk);
         chk("rstFetch", pcValue, 32'(4 * k));
      end
      chk("rstKind", 32'(lastKind), 32'h40);
      @(posedge sys_clk);
      rst_n <= 1'h1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("rstLoad", 32'(pcLoad), 32'h1);
      chk("rstPc", pcValue, VEC_RESET);
      chk("rstStatus", 32'(curStatus), 32'hd3);
      @(posedge sys_clk);
      rdchk(ADDR_LINK, 32'h14, "rstLink");
      apb(1'h1, ADDR_STATUS, 32'hff, d, e);
      rdchk(ADDR_STATUS, 32'hd3, "statusRo");
      apb(1'h0, 8'h20, 32'h0, d, e);
      chk("unmapped", 32'(e), 32'h1);
      apb(1'h1, ADDR_STATUS, 32'h0, d, e);
      rdchk(ADDR_STATUS, 32'h13, "statusClr");
      $display("test reset and registers done");
      foreach (rows[k]) begin
         irqOn   <= rows[k].irq;
         timerOn <= rows[k].fast;
         @(posedge sys_clk);
         step(rows[k].pc, rows[k].und, rows[k].swt);
         exc(rows[k].vec, rows[k].st, rows[k].kd, rows[k].lk, rows[k].sub);
      end
      $display("test entry rows done");
      for (int c = 0; c < 3; c++) begin
         access(1'h1, 2'(c));
         chk("baseWb", 32'(baseWb), 32'(c != 1));
         chk("swapCancel", 32'(swapCancel), 32'(c == 1));
         chk("inhibit", 32'(regInhibit), 32'(c == 2));
         @(posedge sys_clk);
         step(32'h800 + 32'(c * 16), 1'h0, 1'h0);
         chk("inhibitEnd", 32'(regInhibit), 32'h0);
         exc(VEC_DABT, 8'h17, 7'h01, 32'h808 + 32'(c * 16), 4'h8);
      end
      $display("test data abort done");
      access(1'h0, 2'h0);
      @(posedge sys_clk);
      flushPipe <= 1'h1;
      @(posedge sys_clk);
      flushPipe <= 1'h0;
      step(32'h900, 1'h0, 1'h0);
      chk("flushed", 32'(pcLoad), 32'h0);
      @(posedge sys_clk);
      access(1'h0, 2'h0);
      @(posedge sys_clk);
      step(32'ha00, 1'h0, 1'h0);
      exc(VEC_PABT, 8'h17, 7'h08, 32'ha04, 4'h4);
      $display("test prefetch abort done");
      apb(1'h1, ADDR_STATUS, 32'hc0, d, e);
      irqOn   <= 1'h1;
      timerOn <= 3'h7;
      @(posedge sys_clk);
      step(32'hb00, 1'h0, 1'h0);
      chk("masked", 32'(pcLoad), 32'h0);
      @(posedge sys_clk);
      $display("test masking done");
      end_of_test();
   end
endmodule
